/* File: src/power_mode_controller.sv */
// Global power mode controller: mode sequencing, gating and wake control
// Summary of operation
// - Four modes: active, alternate, sleep, hibernate.
// - Active: template-driven; entered on wake, reset, request.
// - Active template bit enables each subsystem.
// - Alternate active by request; any interrupt returns.
// - Alternate active uses its own reduced template.
// - Sleep disables resources, halts code execution.
// - Sleep by request; six listed wake sources.
// - Sleep clocked only by slow oscillator/crystal.
// - Wake latency under 15 us / 100 us.
// - Hibernate: no clocks, retention; pin wake only.
// - Hibernate by request; only hibernate regulator on.
// - Every wake forces active and enables core.
// - Active mode after reset.
// - Disabled resource has its clocks gated.
// - Core self-off undone at next wake.
`include "power_mode_params.svh"
`default_nettype none
module power_mode_controller
   import power_mode_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] mode_req,
   input wire logic req_valid,
   input wire logic [`PM_NUM_SUBSYS-1:0] active_template,
   input wire logic [`PM_NUM_SUBSYS-1:0] alt_template,
   input wire logic cpu_self_off,
   input wire logic irq_any,
   input wire logic [`PM_NUM_SRC-1:0] wake_src,
   input wire logic use_khz_crystal,
   output logic [1:0] global_mode,
   output logic waking,
   output logic [`PM_NUM_SUBSYS-1:0] subsys_en,
   output logic [`PM_NUM_SUBSYS-1:0] subsys_clk_en,
   output logic cpu_run,
   output logic low_speed_oscillator_sel,
   output logic khz_crystal_oscillator_sel,
   output logic main_reg_en,
   output logic sleep_reg_en,
   output logic hibernate_reg_en,
   output logic retain_state
);
   pwr_mode_t mode_reg, mode_next;
   logic waking_reg, waking_next;
   logic [`PM_CNT_W-1:0] cnt_reg, cnt_next;
   logic cpu_off_reg, cpu_off_next;
   logic [`PM_NUM_SUBSYS-1:0] en_reg, en_next;
   logic irq_sync;
   logic [`PM_NUM_SRC-1:0] wake_sync_v;

   wake_sync #(.WIDTH(`PM_NUM_SRC + 1)) u_sync (
      .clk(clk),
      .rst(rst),
      .async_in({irq_any, wake_src}),
      .sync_out({irq_sync, wake_sync_v})
   );

   wire in_run = (mode_reg == MODE_ACTIVE) || (mode_reg == MODE_ALT_ACTIVE);
   wire sleep_wake = |wake_sync_v;
   wire hib_wake = wake_sync_v[`PM_SRC_PIN];
   wire run_wake = irq_sync;
   wire req_ok = req_valid && !waking_reg && in_run;
   wire req_sleep = req_ok && (mode_req == REQ_SLEEP);
   wire req_hib = req_ok && (mode_req == REQ_HIBERNATE);
   wire req_alt = req_ok && (mode_req == REQ_ALT_ACTIVE);
   wire req_act = req_ok && (mode_req == REQ_ACTIVE);
   wire lp_wake = (mode_reg == MODE_SLEEP && sleep_wake) ||
                  (mode_reg == MODE_HIBERNATE && hib_wake);
   wire cnt_done = (cnt_reg == '0);

   always_comb begin
      mode_next = mode_reg;
      waking_next = waking_reg;
      cnt_next = cnt_reg;
      cpu_off_next = cpu_off_reg;
      unique case (mode_reg)
         MODE_ACTIVE, MODE_ALT_ACTIVE: begin
            if (waking_reg) begin
               if (cnt_done) begin
                  waking_next = 1'b0;
               end else begin
                  cnt_next = cnt_reg - 1'b1;
               end
            end else if (req_sleep) begin
               mode_next = MODE_SLEEP;
            end else if (req_hib) begin
               mode_next = MODE_HIBERNATE;
            end else if (mode_reg == MODE_ALT_ACTIVE && run_wake) begin
               mode_next = MODE_ACTIVE;
               cpu_off_next = 1'b0;
            end else if (req_alt) begin
               mode_next = MODE_ALT_ACTIVE;
            end else if (req_act) begin
               mode_next = MODE_ACTIVE;
            end
            if (!waking_reg && cpu_self_off && !run_wake) begin
               cpu_off_next = 1'b1;
            end else if (run_wake) begin
               cpu_off_next = 1'b0;
            end
         end
         MODE_SLEEP, MODE_HIBERNATE: begin
            if (lp_wake) begin
               mode_next = MODE_ACTIVE;
               cpu_off_next = 1'b0;
               waking_next = 1'b1;
               cnt_next = (mode_reg == MODE_SLEEP) ?
                  `PM_CNT_W'(`PM_SLEEP_WAKE_CYC) :
                  `PM_CNT_W'(`PM_HIB_WAKE_CYC);
            end
         end
      endcase
   end

   always_comb begin
      unique case (mode_next)
         MODE_ACTIVE: en_next = active_template;
         MODE_ALT_ACTIVE: en_next = alt_template;
         MODE_SLEEP, MODE_HIBERNATE: en_next = '0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mode_reg <= MODE_ACTIVE;
         waking_reg <= 1'b0;
         cnt_reg <= '0;
         cpu_off_reg <= 1'b0;
         en_reg <= '0;
      end else begin
         mode_reg <= mode_next;
         waking_reg <= waking_next;
         cnt_reg <= cnt_next;
         cpu_off_reg <= cpu_off_next;
         en_reg <= en_next;
      end
   end

   wire is_sleep = (mode_reg == MODE_SLEEP);
   wire is_hib = (mode_reg == MODE_HIBERNATE);
   assign global_mode = mode_reg;
   assign waking = waking_reg;
   assign subsys_en = waking_reg ? '0 : en_reg;
   assign subsys_clk_en = subsys_en;
   assign cpu_run = in_run && !waking_reg && !cpu_off_reg;
   assign low_speed_oscillator_sel = is_sleep && !use_khz_crystal;
   assign khz_crystal_oscillator_sel = is_sleep && use_khz_crystal;
   assign main_reg_en = in_run;
   assign sleep_reg_en = is_sleep;
   assign hibernate_reg_en = is_hib;
   assign retain_state = is_hib;

   // Cycles spent waking, measured for the latency checks
   localparam int SLEEP_LAT_MAX =
      `PM_SLEEP_WAKE_LIM - `PM_WAKE_SYNC_CYC - 1;
   localparam int HIB_LAT_MAX = `PM_HIB_WAKE_LIM - `PM_WAKE_SYNC_CYC - 1;
   logic [`PM_CNT_W-1:0] lat_reg;
   logic lat_hib_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         lat_reg <= '0;
         lat_hib_reg <= 1'b0;
      end else if (lp_wake) begin
         lat_reg <= '0;
         lat_hib_reg <= is_hib;
      end else if (waking_reg) begin
         lat_reg <= lat_reg + 1'b1;
      end
   end

   AST_RESET_ACTIVE: assert property (
      @(posedge clk) rst |=> mode_reg == MODE_ACTIVE)
      else $error("mode not active after reset");
   AST_LP_ONLY_FROM_RUN: assert property (
      @(posedge clk) disable iff (rst)
      !in_run |=> in_run ? mode_reg == MODE_ACTIVE : $stable(mode_reg))
      else $error("low power mode left other than to active");
   AST_WAKE_VIA_ACTIVE: assert property (
      @(posedge clk) disable iff (rst)
      waking_reg |-> mode_reg == MODE_ACTIVE && !cpu_run)
      else $error("mode changed during wake window");
   AST_SLEEP_WAKE: assert property (
      @(posedge clk) disable iff (rst)
      is_sleep && sleep_wake |=> mode_reg == MODE_ACTIVE && waking_reg)
      else $error("sleep did not wake");
   AST_HIB_PIN_ONLY: assert property (
      @(posedge clk) disable iff (rst)
      is_hib && !hib_wake |=> is_hib)
      else $error("hibernate left without pin wake");
   AST_SLEEP_LAT: assert property (
      @(posedge clk) disable iff (rst)
      waking_reg && !lat_hib_reg |-> lat_reg < SLEEP_LAT_MAX)
      else $error("sleep wake latency exceeded");
   AST_HIB_LAT: assert property (
      @(posedge clk) disable iff (rst)
      waking_reg && lat_hib_reg |-> lat_reg < HIB_LAT_MAX)
      else $error("hibernate wake latency exceeded");
   AST_SLEEP_GATED: assert property (
      @(posedge clk) disable iff (rst)
      is_sleep |-> subsys_en == '0 && !cpu_run)
      else $error("resources on in sleep");
   AST_HIB_GATED: assert property (
      @(posedge clk) disable iff (rst)
      is_hib |-> subsys_en == '0 && !cpu_run && !main_reg_en && !sleep_reg_en)
      else $error("resources on in hibernate");
   AST_ALT_TEMPLATE: assert property (
      @(posedge clk) disable iff (rst)
      mode_reg == MODE_ALT_ACTIVE && $stable(mode_reg) && !waking_reg
      && $stable(alt_template) |-> subsys_en == alt_template)
      else $error("alt template not applied");
   AST_CPU_WAKE: assert property (
      @(posedge clk) disable iff (rst)
      lp_wake |=> !cpu_off_reg)
      else $error("core not re-enabled on wake");
   AST_CLK_GATE: assert property (
      @(posedge clk) disable iff (rst)
      mode_reg == MODE_ACTIVE && $stable(active_template)
      |-> (subsys_clk_en & ~active_template) == '0)
      else $error("clock of disabled subsystem not gated");
   COV_CORE_REWAKE: cover property (@(posedge clk)
      cpu_off_reg ##1 !cpu_off_reg);
   COV_SLEEP_WAKE: cover property (@(posedge clk)
      is_sleep ##1 mode_reg == MODE_ACTIVE);
   COV_HIB_WAKE: cover property (@(posedge clk)
      is_hib ##1 mode_reg == MODE_ACTIVE);
   COV_ALT_IRQ: cover property (@(posedge clk)
      mode_reg == MODE_ALT_ACTIVE ##1 mode_reg == MODE_ACTIVE);
endmodule : power_mode_controller
`default_nettype wire

/* File: src/power_mode_params.svh */
// Constants for the global power mode controller
`ifndef POWER_MODE_PARAMS_SVH
`define POWER_MODE_PARAMS_SVH
`define PM_NUM_SUBSYS 8
`define PM_CPU_BIT 0
`define PM_SLEEP_WAKE_NS 15000
`define PM_HIB_WAKE_NS 100000
`define PM_CLK_PERIOD_NS 4
`define PM_WAKE_SYNC_CYC 3
`define PM_SLEEP_WAKE_LIM (`PM_SLEEP_WAKE_NS / `PM_CLK_PERIOD_NS)
`define PM_HIB_WAKE_LIM (`PM_HIB_WAKE_NS / `PM_CLK_PERIOD_NS)
// Window leaves room for the synchroniser and the mode edge
`define PM_SLEEP_WAKE_CYC (`PM_SLEEP_WAKE_LIM - `PM_WAKE_SYNC_CYC - 2)
`define PM_HIB_WAKE_CYC (`PM_HIB_WAKE_LIM - `PM_WAKE_SYNC_CYC - 2)
`define PM_CNT_W 15
`define PM_SRC_CMP 0
`define PM_SRC_PIN 1
`define PM_SRC_I2C 2
`define PM_SRC_RTC 3
`define PM_SRC_TIMEWHEEL 4
`define PM_SRC_LOW_VOLT 5
`define PM_NUM_SRC 6
`endif

/* File: src/power_mode_pkg.sv */
// Types for the global power mode controller
`default_nettype none
package power_mode_pkg;
   typedef enum logic [1:0] {
      MODE_ACTIVE = 2'h0,
      MODE_ALT_ACTIVE = 2'h1,
      MODE_SLEEP = 2'h2,
      MODE_HIBERNATE = 2'h3
   } pwr_mode_t;
   typedef enum logic [2:0] {
      REQ_NONE = 3'h0,
      REQ_ACTIVE = 3'h1,
      REQ_ALT_ACTIVE = 3'h2,
      REQ_SLEEP = 3'h3,
      REQ_HIBERNATE = 3'h4
   } mode_req_t;
endpackage : power_mode_pkg
`default_nettype wire

/* File: src/wake_sync.sv */
// Two-flop synchroniser bank for wake sources
`default_nettype none
module wake_sync #(
   parameter int WIDTH = 6
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk) begin
            if (rst) begin
               meta_reg[i] <= 1'b0;
               sync_reg[i] <= 1'b0;
            end else begin
               meta_reg[i] <= async_in[i];
               sync_reg[i] <= meta_reg[i];
            end
         end
      end
   endgenerate
   assign sync_out = sync_reg;
endmodule : wake_sync
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking testbench for the global power mode controller
`include "power_mode_params.svh"
`default_nettype none
module tb
   import power_mode_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, cpu_self_off = 1'b0;
   logic irq_any = 1'b0, use_khz_crystal = 1'b0;
   logic [2:0] mode_req = 3'h0;
   logic [7:0] act_t = 8'h5b, alt_t = 8'h24, subsys_en, subsys_clk_en;
   logic [5:0] wake_src = 6'h00;
   logic [1:0] global_mode;
   logic waking, cpu_run, lso_sel, khz_sel, main_en, slp_en, hib_en, ret;
   int errors = 0, cmp_count = 0;
   power_mode_controller u_dut (.clk(clk), .rst(rst), .mode_req(mode_req),
      .req_valid(req_valid), .active_template(act_t), .alt_template(alt_t),
      .cpu_self_off(cpu_self_off), .irq_any(irq_any), .wake_src(wake_src),
      .use_khz_crystal(use_khz_crystal), .global_mode(global_mode),
      .waking(waking), .subsys_en(subsys_en), .subsys_clk_en(subsys_clk_en),
      .cpu_run(cpu_run), .low_speed_oscillator_sel(lso_sel),
      .khz_crystal_oscillator_sel(khz_sel), .main_reg_en(main_en),
      .sleep_reg_en(slp_en), .hibernate_reg_en(hib_en), .retain_state(ret));
   initial begin
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim;
      if (errors == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim
   task automatic req(input logic [2:0] m);
      @(negedge clk) mode_req = m;
      req_valid = 1'b1;
      @(negedge clk) req_valid = 1'b0;
      mode_req = 3'h0;
   endtask : req
   task automatic wmode(input logic [1:0] m);
      for (int i = 0; i < 6 && global_mode !== m; i++) @(negedge clk);
      chk(global_mode, m);
   endtask : wmode
   // Counts the wake window and checks it against its bounds
   task automatic wwin(input int lo, input int hi, input time t0,
         input int lim_ns);
      int n;
      n = 0;
      chk(waking, 1'b1);
      while (waking === 1'b1 && n < 30000) begin
         @(negedge clk);
         n++;
      end
      chk(n > lo && n <= hi, 1'b1);
      chk(($time - t0) < lim_ns, 1'b1);
      chk(cpu_run, 1'b1);
      chk(subsys_en, act_t);
   endtask : wwin
   task automatic t_reset;
      chk(global_mode, MODE_ACTIVE);
      chk(cpu_run, 1'b1);
      repeat (2) @(negedge clk);
      chk(subsys_en, act_t);
      chk(subsys_clk_en, act_t);
      chk(main_en, 1'b1);
   endtask : t_reset
   task automatic t_alt;
      req(REQ_ALT_ACTIVE);
      wmode(MODE_ALT_ACTIVE);
      repeat (2) @(negedge clk);
      chk(subsys_en, alt_t);
      chk(subsys_clk_en, alt_t);
      irq_any = 1'b1;
      wmode(MODE_ACTIVE);
      irq_any = 1'b0;
      repeat (2) @(negedge clk);
      chk(subsys_en, act_t);
   endtask : t_alt
   task automatic t_sleep;
      time t0;
      for (int s = 0; s < 6; s++) begin
         use_khz_crystal = s[0];
         req(REQ_SLEEP);
         wmode(MODE_SLEEP);
         repeat (2) @(negedge clk);
         chk({subsys_en, cpu_run, main_en, slp_en}, 11'h001);
         chk({lso_sel, khz_sel}, {~s[0], s[0]});
         req(REQ_ACTIVE);
         repeat (4) @(negedge clk);
         chk(global_mode, MODE_SLEEP);
         wake_src = 6'h01 << s;
         t0 = $time;
         wmode(MODE_ACTIVE);
         wake_src = 6'h00;
         wwin(0, `PM_SLEEP_WAKE_CYC + 1, t0, `PM_SLEEP_WAKE_NS);
      end
   endtask : t_sleep
   task automatic t_hib;
      time t0;
      req(REQ_HIBERNATE);
      wmode(MODE_HIBERNATE);
      repeat (2) @(negedge clk);
      chk({hib_en, ret, main_en, slp_en, lso_sel, khz_sel}, 6'h30);
      chk({subsys_en, cpu_run}, 9'h000);
      wake_src = 6'h3d;
      irq_any = 1'b1;
      repeat (8) @(negedge clk);
      chk(global_mode, MODE_HIBERNATE);
      irq_any = 1'b0;
      wake_src = 6'h02;
      t0 = $time;
      wmode(MODE_ACTIVE);
      wake_src = 6'h00;
      req(REQ_SLEEP);
      chk(global_mode, MODE_ACTIVE);
      wwin(`PM_SLEEP_WAKE_CYC + 1, `PM_HIB_WAKE_CYC + 1, t0,
         `PM_HIB_WAKE_NS);
   endtask : t_hib
   task automatic t_self_off;
      cpu_self_off = 1'b1;
      repeat (3) @(negedge clk);
      chk(cpu_run, 1'b0);
      cpu_self_off = 1'b0;
      irq_any = 1'b1;
      repeat (5) @(negedge clk);
      chk(cpu_run, 1'b1);
      irq_any = 1'b0;
   endtask : t_self_off
   initial begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_alt();
      t_sleep();
      t_hib();
      t_self_off();
      end_sim();
   end
   initial begin
      #300000;
      errors++;
      end_sim();
   end
endmodule : tb
`default_nettype wire
